/* rtl/audio_link_global_control.sv */
// Operation
// RULE1: While run is set, digital audio uses slot pair chosen by slot map.
// RULE2: No overlap check between digital-audio slots and PCM slots; software avoids conflicts.
// RULE3: Width field 00 selects 16-bit, 01 selects 20-bit; others reserved.
// RULE4: Width setting affects only PCM output, not mic or digital-audio channels.
// RULE5: Wide samples are 32-bit words; sample taken from top bits.
// RULE6: Channel field 00 two, 01 four, 10 six channels; 11 reserved.
// RULE7: Input 2 wake raises interrupt only when its enable is set.
// RULE8: Input 1 wake raises interrupt only when its enable is set.
// RULE9: Input 0 wake raises interrupt only when its enable is set.
// RULE10: Link shut-off disables all link outputs; clearing restores normal operation.
// RULE11: Run bit starts bus master; clearing pauses and keeps state.
// RULE12: Input 2 wake sets sticky flag, cleared by writing one.
// RULE13: Reserved bits read zero, ignore writes; register resets to zero.
`timescale 1ns/1ps
`default_nettype none
`include "audio_link_params.svh"
module audio_link_global_control (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Wake flag on input 2, write-one-to-clear
  input wire logic wake2_clear,
  output logic codec_in2_wake_flag,
  // Bus master run, per-channel
  input wire logic bus_master_run,
  // Codec inputs from pins
  input wire logic [2:0] codec_serial_input,
  // Sample path for PCM out, memory word in
  input wire logic [31:0] pcm_mem_word,
  output logic [19:0] pcm_sample,
  // Link outputs
  input wire logic link_sync_in,
  input wire logic link_sdout_in,
  output logic link_sync,
  output logic link_sdout,
  output logic link_out_en,
  // Decoded controls
  output audio_link_pkg::slot_mask_t spdif_slots,
  output audio_link_pkg::sample_width_e pcm_out_sample_width,
  output audio_link_pkg::chan_mode_e pcm_chan_mode,
  output logic [2:0] codec_wake_irq
);
  import audio_link_pkg::*;

  // ==========================================
  // Internal state and next values
  logic [31:0] ctrl, next_ctrl;
  logic [31:0] next_rdata;
  logic [19:0] next_sample;
  logic next_link_sync;
  logic next_link_sdout;
  logic next_link_out_en;
  // Per-input wake status and controls
  logic [2:0] wake_flags;
  logic [2:0] wake_en;
  logic [2:0] wake_clear;
  // Decoded register fields
  logic link_off;
  slot_map_e slot_map;
  slot_mask_t slot_mask;

  // ==========================================
  // Slot pair decode
  function automatic slot_mask_t slot_decode(input slot_map_e m);
    slot_mask_t s;
    s = `SLOT_MASK_NONE;
    case (m)
      slot_7_8: s = `SLOT_MASK_7_8;
      slot_6_9: s = `SLOT_MASK_6_9;
      slot_10_11: s = `SLOT_MASK_10_11;
      default: s = `SLOT_MASK_NONE; // Reserved map sends nothing
    endcase
    return s;
  endfunction

  // Register select, shared by the write and read paths
  function automatic logic hits_ctrl(input logic [7:0] a);
    return a == `GLOB_CTRL_OFFSET;
  endfunction

  // Left-align a narrow sample, or take the top bits of a wide word
  function automatic logic [19:0] align_sample(input sample_width_e w, input logic [31:0] word);
    logic [19:0] s;
    if (w == width_20) begin
      s = word[`WORD_HI:`WIDE_SHIFT]; // RULE5
    end else begin
      s = {word[`NARROW_HI:0], `NARROW_PAD};
    end
    return s;
  endfunction

  // ==========================================
  // Control register
  // Reserved bits are masked on the way in, so they read back as zero
  // without a separate read mask
  always_comb begin
    next_ctrl = ctrl;
    if (reg_wr && hits_ctrl(reg_addr)) begin
      next_ctrl = reg_wdata & `GLOB_CTRL_WMASK; // RULE13
    end
  end

  // Control register flops, frozen while the clock enable is low
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl <= `GLOB_CTRL_RESET; // RULE13
    end else if (clk_en) begin
      ctrl <= next_ctrl;
    end
  end

  // ==========================================
  // Field decode
  // Reserved width and channel codes pass through unchanged; the
  // consumers treat them as undefined
  assign wake_en = ctrl[`WAKE_EN_HI:`WAKE_EN_LO];
  assign link_off = ctrl[`LINK_OFF_BIT];
  assign slot_map = slot_map_e'(ctrl[`SLOT_SEL_HI:`SLOT_SEL_LO]);
  assign slot_mask = slot_decode(slot_map);
  assign pcm_out_sample_width = sample_width_e'(ctrl[`WIDTH_HI:`WIDTH_LO]); // RULE3
  assign pcm_chan_mode = chan_mode_e'(ctrl[`CHAN_HI:`CHAN_LO]); // RULE6
  // Slots driven only while running; overlap with PCM slots is not
  // checked, so a clashing map is left to software
  assign spdif_slots = bus_master_run ? slot_mask : `SLOT_MASK_NONE; // RULE1 RULE2 RULE11

  // ==========================================
  // Wake flags per codec input
  // Inputs 0 and 1 have no status bit: their flag clears every cycle,
  // so each wake edge gives a one-cycle interrupt pulse while its enable bit is set
  // Pins are asynchronous; each flag module synchronises its own input
  assign wake_clear = {wake2_clear, 2'h3};
  genvar i;
  for (i = 0; i < `NUM_CODECS; i++) begin : g_wake
    wake_flag u_wake (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .wake_pin(codec_serial_input[i]),
      .clear(wake_clear[i]),
      .irq_en(wake_en[i]),
      .flag(wake_flags[i]),
      .irq(codec_wake_irq[i]) // RULE7 RULE8 RULE9
    );
  end
  // Only input 2 keeps a sticky status bit
  assign codec_in2_wake_flag = wake_flags[`STATUS_INPUT]; // RULE12

  // ==========================================
  // PCM sample fetch, PCM channel only; mic and digital-audio
  // paths never see the width field
  always_comb begin
    next_sample = align_sample(pcm_out_sample_width, pcm_mem_word); // RULE4
  end

  // Sample flops
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pcm_sample <= `SAMPLE_RESET;
    end else if (clk_en) begin
      pcm_sample <= next_sample;
    end
  end

  // ==========================================
  // Register read
  // Unmapped addresses read zero; the data holds until the next read
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      next_rdata = hits_ctrl(reg_addr) ? ctrl : `RDATA_RESET; // RULE13
    end
  end

  // Read data flops
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= `RDATA_RESET;
    end else if (clk_en) begin
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================
  // Link outputs
  // Shut-off forces data low and drops the enable, so the pads fall to
  // their pull-downs; registered so toggling the bit cannot glitch a pin
  always_comb begin
    next_link_sync = link_sync_in;
    next_link_sdout = link_sdout_in;
    next_link_out_en = 1'b1;
    if (link_off) begin
      next_link_sync = 1'b0; // RULE10
      next_link_sdout = 1'b0; // RULE10
      next_link_out_en = 1'b0; // RULE10
    end
  end

  // Link output flops, disabled while in reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      link_sync <= 1'b0;
      link_sdout <= 1'b0;
      link_out_en <= 1'b0;
    end else if (clk_en) begin
      link_sync <= next_link_sync;
      link_sdout <= next_link_sdout;
      link_out_en <= next_link_out_en;
    end
  end
endmodule
`default_nettype wire

/* rtl/audio_link_params.svh */
`ifndef AUDIO_LINK_PARAMS_SVH
`define AUDIO_LINK_PARAMS_SVH
// ==========================================
// Register map
`define GLOB_CTRL_OFFSET 8'h2C
`define GLOB_CTRL_RESET 32'h0000_0000
// Writable bits: 31:30, 23:20, 6:3
`define GLOB_CTRL_WMASK 32'hC0F0_0078
// ==========================================
// Field positions
`define SLOT_SEL_HI 31
`define SLOT_SEL_LO 30
`define WIDTH_HI 23
`define WIDTH_LO 22
`define CHAN_HI 21
`define CHAN_LO 20
`define WAKE_EN_HI 6
`define WAKE_EN_LO 4
`define LINK_OFF_BIT 3
// ==========================================
// Sample fetch
`define WIDE_SHIFT 12
`define WORD_HI 31
`define NARROW_HI 15
`define NARROW_PAD 4'h0
`define SAMPLE_RESET 20'h0_0000
`define RDATA_RESET 32'h0000_0000
`define NUM_CODECS 3
`define STATUS_INPUT 2
// ==========================================
// Slot pair masks, bit n is slot n
`define SLOT_MASK_NONE 12'h000
`define SLOT_MASK_7_8 12'h180
`define SLOT_MASK_6_9 12'h240
`define SLOT_MASK_10_11 12'hC00
`endif

/* rtl/audio_link_pkg.sv */
`default_nettype none
package audio_link_pkg;
  // Slot pair carrying the digital-audio stream
  typedef enum logic [1:0] {
    slot_reserved = 2'h0,
    slot_7_8 = 2'h1,
    slot_6_9 = 2'h2,
    slot_10_11 = 2'h3
  } slot_map_e;
  // PCM output sample width
  typedef enum logic [1:0] {
    width_16 = 2'h0,
    width_20 = 2'h1,
    width_res2 = 2'h2,
    width_res3 = 2'h3
  } sample_width_e;
  // PCM output channel count
  typedef enum logic [1:0] {
    chan_2 = 2'h0,
    chan_4 = 2'h1,
    chan_6 = 2'h2,
    chan_res = 2'h3
  } chan_mode_e;
  typedef logic [11:0] slot_mask_t;
endpackage
`default_nettype wire

/* rtl/wake_flag.sv */
`timescale 1ns/1ps
`default_nettype none
`include "audio_link_params.svh"
module wake_flag (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Event in, synchronised
  input wire logic wake_pin,
  // Clear strobe and enable
  input wire logic clear,
  input wire logic irq_en,
  // Status out
  output logic flag,
  output logic irq
);
  logic sync1, sync2, last;
  logic next_flag;
  logic rise;
  // ==========================================
  // Edge detect and sticky flag
  always_comb begin
    rise = sync2 & ~last;
    next_flag = flag;
    if (clear) begin
      next_flag = 1'b0;
    end
    if (rise) begin
      next_flag = 1'b1;
    end
  end
  // Registers, set wins over clear
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      last <= 1'b0;
      flag <= 1'b0;
    end else if (clk_en) begin
      sync1 <= wake_pin;
      sync2 <= sync1;
      last <= sync2;
      flag <= next_flag;
    end
  end
  // Interrupt gated by its enable
  assign irq = flag & irq_en;
endmodule
`default_nettype wire

/* dv/codec_model.sv */
`timescale 1ns/1ps
`default_nettype none
module codec_model (
  // Clock and resume requests
  input wire logic ref_clk,
  input wire logic [2:0] wake_req,
  // Lines into the controller
  output logic [2:0] codec_serial_input
);
  // Resume event: line leaves its idle low
  always_ff @(posedge ref_clk) codec_serial_input <= wake_req;
endmodule
`default_nettype wire

/* dv/audio_link_global_control_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module alink_chk (
  // Clock and register port
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // Controls and status
  input wire logic bus_master_run,
  input wire logic [2:0] codec_serial_input,
  input wire logic codec_in2_wake_flag,
  input wire logic wake2_clear,
  input wire logic link_out_en,
  input wire audio_link_pkg::slot_mask_t spdif_slots,
  input wire audio_link_pkg::sample_width_e pcm_out_sample_width,
  input wire audio_link_pkg::chan_mode_e pcm_chan_mode,
  input wire logic [2:0] codec_wake_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Accesses taken at this edge
  wire logic wr_c = reg_wr && clk_en && reg_addr == 8'h2C;
  wire logic rd_o = reg_rd && clk_en && reg_addr != 8'h2C;
  a_width_write: assert property (wr_c |=> pcm_out_sample_width == $past(reg_wdata[23:22]))
    else $error("width not taken");
  a_chan_write: assert property (wr_c |=> pcm_chan_mode == $past(reg_wdata[21:20]))
    else $error("channel mode not taken");
  a_slot_idle: assert property (!bus_master_run |-> spdif_slots == 12'h0)
    else $error("slots while paused");
  a_off_write: assert property (wr_c && reg_wdata[3] ##1 clk_en |=> !link_out_en)
    else $error("link still enabled");
  a_irq_flag: assert property (codec_wake_irq[2] |-> codec_in2_wake_flag)
    else $error("irq without flag");
  a_flag_hold: assert property (codec_in2_wake_flag && !wake2_clear |=> codec_in2_wake_flag)
    else $error("flag lost");
  a_wake_set: assert property ($rose(codec_serial_input[2]) |-> ##[1:4] codec_in2_wake_flag)
    else $error("flag not set");
  a_read_other: assert property (rd_o |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind audio_link_global_control alink_chk i_chk (
  .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .bus_master_run(bus_master_run), .codec_serial_input(codec_serial_input),
  .codec_in2_wake_flag(codec_in2_wake_flag), .wake2_clear(wake2_clear),
  .link_out_en(link_out_en), .spdif_slots(spdif_slots),
  .pcm_out_sample_width(pcm_out_sample_width), .pcm_chan_mode(pcm_chan_mode),
  .codec_wake_irq(codec_wake_irq)
);
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import audio_link_pkg::*;
  logic ref_clk, reset, clk_en, reg_wr, reg_rd, wake2_clear, bus_master_run, link_sync_in, link_sdout_in;
  logic link_sync, link_sdout, link_out_en, codec_in2_wake_flag;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, pcm_mem_word;
  logic [2:0] codec_serial_input, codec_wake_irq, wake_req, seen;
  logic [19:0] pcm_sample;
  slot_mask_t spdif_slots;
  sample_width_e pcm_out_sample_width;
  chan_mode_e pcm_chan_mode;
  int fails, compares, cyc;
  codec_model i_codec (
    .ref_clk(ref_clk),
    .wake_req(wake_req),
    .codec_serial_input(codec_serial_input)
  );
  audio_link_global_control i_dut (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .wake2_clear(wake2_clear), .codec_in2_wake_flag(codec_in2_wake_flag),
    .bus_master_run(bus_master_run), .codec_serial_input(codec_serial_input),
    .pcm_mem_word(pcm_mem_word), .pcm_sample(pcm_sample),
    .link_sync_in(link_sync_in), .link_sdout_in(link_sdout_in),
    .link_sync(link_sync), .link_sdout(link_sdout), .link_out_en(link_out_en),
    .spdif_slots(spdif_slots), .pcm_out_sample_width(pcm_out_sample_width),
    .pcm_chan_mode(pcm_chan_mode), .codec_wake_irq(codec_wake_irq)
  );
  // Clock and run ceiling
  initial begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      stop_test;
    end
  end
  task automatic stop_test;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  // Register accesses
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge ref_clk);
    reg_wr <= 0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge ref_clk);
    reg_rd <= 0;
    @(posedge ref_clk);
    chk(reg_rdata, e);
  endtask
  // Codec wake on one input, irq collected
  task automatic pulse(input int i);
    seen = 0;
    wake_req[i] <= 1;
    repeat (6) @(posedge ref_clk) seen |= codec_wake_irq;
    wake_req[i] <= 0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic clr;
    wake2_clear <= 1;
    @(posedge ref_clk);
    wake2_clear <= 0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic t_regs;
    rd(8'h2C, 32'h0);
    wr(8'h2C, 32'hFFFFFFFF);
    rd(8'h2C, 32'hC0F00078);
    wr(8'h30, 32'h0);
    rd(8'h2C, 32'hC0F00078);
    rd(8'h30, 32'h0);
  endtask
  task automatic t_fields;
    logic [11:0] m [4] = '{12'h0, 12'h180, 12'h240, 12'hC00};
    bus_master_run <= 1;
    for (int i = 0; i < 4; i++) begin
      wr(8'h2C, {i[1:0], 7'h0, i[0], i[1:0], 20'h0});
      chk(spdif_slots, m[i]);
      chk(pcm_out_sample_width, i[0]);
      chk(pcm_chan_mode, i[1:0]);
      if (i[0]) chk(pcm_sample, pcm_mem_word[31:12]);
      else chk(pcm_sample, {pcm_mem_word[15:0], 4'h0});
    end
    bus_master_run <= 0;
    @(posedge ref_clk);
    chk(spdif_slots, 12'h0);
  endtask
  task automatic t_wake;
    wr(8'h2C, 32'h70);
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      chk(seen, 3'h1 << i);
    end
    clr;
    wr(8'h2C, 32'h0);
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      chk(seen, 3'h0);
    end
    chk(codec_in2_wake_flag, 1'h1);
    wr(8'h2C, 32'h40);
    chk(codec_wake_irq, 3'h4);
    clr;
    chk(codec_in2_wake_flag, 1'h0);
  endtask
  task automatic t_link;
    clk_en <= 0;
    wr(8'h2C, 32'h8);
    clk_en <= 1;
    rd(8'h2C, 32'h40);
    wr(8'h2C, 32'h8);
    chk({link_out_en, link_sync, link_sdout}, 3'h0);
    wr(8'h2C, 32'h0);
    chk({link_out_en, link_sync, link_sdout}, 3'h7);
    {link_sync_in, link_sdout_in} <= 2'h1;
    repeat (2) @(posedge ref_clk);
    chk({link_out_en, link_sync, link_sdout}, 3'h5);
  endtask
  // Main sequence
  initial begin
    reset = 1;
    {clk_en, link_sync_in, link_sdout_in} = 3'h7;
    {reg_wr, reg_rd, wake2_clear, bus_master_run} = 4'h0;
    {reg_addr, reg_wdata, wake_req} = 43'h0;
    pcm_mem_word = 32'hABCDE123;
    repeat (6) @(posedge ref_clk);
    reset <= 0;
    @(posedge ref_clk);
    t_regs;
    t_fields;
    t_wake;
    t_link;
    stop_test;
  end
endmodule
`default_nettype wire
